//--- pkg/bcb_defs.svh
// Register offsets, field positions and reset values of the channel B break conditions
`ifndef BCB_DEFS_SVH
`define BCB_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define BCB_OFS_ADDR_MASK_LOW  32'hffffff66
`define BCB_OFS_CYCLE_SELECT   32'hffffff68
`define BCB_OFS_DATA_HIGH      32'hffffff70
`define BCB_OFS_DATA_LOW       32'hffffff72
`define BCB_OFS_DATA_MASK_HIGH 32'hffffff74
`define BCB_OFS_DATA_MASK_LOW  32'hffffff76

// ****************************************
// Field positions of the cycle select register
// ****************************************
`define BCB_CP_HI 7
`define BCB_CP_LO 6
`define BCB_ID_HI 5
`define BCB_ID_LO 4
`define BCB_RW_HI 3
`define BCB_RW_LO 2
`define BCB_SZ_HI 1
`define BCB_SZ_LO 0

// ****************************************
// Reset values
// ****************************************
`define BCB_RST_REG16 16'h0000
`define BCB_RST_SEL8  8'h00

`endif

//--- pkg/bcb_pkg.sv
// Types shared by the channel B break condition logic
package bcb_pkg;

	// Operand size of a monitored cycle, and size select codes
	typedef enum logic [1:0] {
		BCB_SZ_ANY  = 2'h0,
		BCB_SZ_BYTE = 2'h1,
		BCB_SZ_WORD = 2'h2,
		BCB_SZ_LONG = 2'h3
	} bcb_size_t;

	// Two-bit selection field
	typedef logic [1:0] bcb_sel_t;

endpackage

//--- rtl/bcb_mask_cmp.sv
// Masked equality compare, one bit position per generate entry
`timescale 1ns/1ps
module bcb_mask_cmp #(
	parameter int W = 32
) (
	// Operands
	input  wire logic [W-1:0] i_value,
	input  wire logic [W-1:0] i_ref,
	input  wire logic [W-1:0] i_mask,
	// Result
	output logic              o_hit
);

	logic [W-1:0] bit_hit;

	// A set mask bit drops that position from the compare
	for (genvar i = 0; i < W; i++) begin : g_bit
		assign bit_hit[i] = i_mask[i] | (i_value[i] == i_ref[i]);
	end

	assign o_hit = &bit_hit;

endmodule

//--- rtl/bcb_top.sv
// Channel B break condition registers and match logic
`timescale 1ns/1ps
`include "bcb_defs.svh"

module bcb_top (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	// Register port
	input  wire logic [31:0] i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [15:0] o_rdata,
	// Channel B address value and upper address mask
	input  wire logic [31:0] i_break_addr_b,
	input  wire logic [15:0] i_addr_mask_b_high,
	// Monitored bus cycle
	input  wire logic        i_mon_valid,
	input  wire logic [31:0] i_mon_addr,
	input  wire logic [31:0] i_mon_data,
	input  wire logic        i_mon_periph,
	input  wire logic        i_mon_fetch,
	input  wire logic        i_mon_write,
	input  wire logic [1:0]  i_mon_size,
	// Match result
	output logic             o_match_b
);

	// ****************************************
	// Registers
	// ****************************************
	logic [15:0] addr_mask_b_low_bits;
	logic [15:0] break_data_b_high_bits;
	logic [15:0] break_data_b_low_bits;
	logic [15:0] data_mask_b_high_bits;
	logic [15:0] data_mask_b_low_bits;
	logic [7:0]  cycle_select;
	logic [15:0] next_addr_mask_b_low_bits;
	logic [15:0] next_break_data_b_high_bits;
	logic [15:0] next_break_data_b_low_bits;
	logic [15:0] next_data_mask_b_high_bits;
	logic [15:0] next_data_mask_b_low_bits;
	logic [7:0]  next_cycle_select;
	logic [15:0] next_rdata;

	bcb_pkg::bcb_sel_t cpu_periph_select_b;
	bcb_pkg::bcb_sel_t fetch_data_select_b;
	bcb_pkg::bcb_sel_t read_write_select_b;
	bcb_pkg::bcb_sel_t operand_size_select_b;

	assign cpu_periph_select_b   = cycle_select[`BCB_CP_HI:`BCB_CP_LO];
	assign fetch_data_select_b   = cycle_select[`BCB_ID_HI:`BCB_ID_LO];
	assign read_write_select_b   = cycle_select[`BCB_RW_HI:`BCB_RW_LO];
	assign operand_size_select_b = cycle_select[`BCB_SZ_HI:`BCB_SZ_LO];

	always_comb begin
		next_addr_mask_b_low_bits   = addr_mask_b_low_bits;
		next_break_data_b_high_bits = break_data_b_high_bits;
		next_break_data_b_low_bits  = break_data_b_low_bits;
		next_data_mask_b_high_bits  = data_mask_b_high_bits;
		next_data_mask_b_low_bits   = data_mask_b_low_bits;
		next_cycle_select           = cycle_select;
		if (i_wr) begin
			unique case (i_addr)
				`BCB_OFS_ADDR_MASK_LOW:  next_addr_mask_b_low_bits = i_wdata;
				`BCB_OFS_DATA_HIGH:      next_break_data_b_high_bits = i_wdata;
				`BCB_OFS_DATA_LOW:       next_break_data_b_low_bits = i_wdata;
				`BCB_OFS_DATA_MASK_HIGH: next_data_mask_b_high_bits = i_wdata;
				`BCB_OFS_DATA_MASK_LOW:  next_data_mask_b_low_bits = i_wdata;
				`BCB_OFS_CYCLE_SELECT:   next_cycle_select = i_wdata[7:0];
				default: begin
				end
			endcase
		end
	end

	// Read data in the cycle after the read strobe, zero elsewhere
	always_comb begin
		next_rdata = 16'h0000;
		if (i_rd) begin
			unique case (i_addr)
				`BCB_OFS_ADDR_MASK_LOW:  next_rdata = addr_mask_b_low_bits;
				`BCB_OFS_DATA_HIGH:      next_rdata = break_data_b_high_bits;
				`BCB_OFS_DATA_LOW:       next_rdata = break_data_b_low_bits;
				`BCB_OFS_DATA_MASK_HIGH: next_rdata = data_mask_b_high_bits;
				`BCB_OFS_DATA_MASK_LOW:  next_rdata = data_mask_b_low_bits;
				`BCB_OFS_CYCLE_SELECT:   next_rdata = {8'h00, cycle_select};
				default:                 next_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			addr_mask_b_low_bits   <= `BCB_RST_REG16;
			break_data_b_high_bits <= `BCB_RST_REG16;
			break_data_b_low_bits  <= `BCB_RST_REG16;
			data_mask_b_high_bits  <= `BCB_RST_REG16;
			data_mask_b_low_bits   <= `BCB_RST_REG16;
			cycle_select           <= `BCB_RST_SEL8;
			o_rdata                <= `BCB_RST_REG16;
		end else begin
			addr_mask_b_low_bits   <= next_addr_mask_b_low_bits;
			break_data_b_high_bits <= next_break_data_b_high_bits;
			break_data_b_low_bits  <= next_break_data_b_low_bits;
			data_mask_b_high_bits  <= next_data_mask_b_high_bits;
			data_mask_b_low_bits   <= next_data_mask_b_low_bits;
			cycle_select           <= next_cycle_select;
			o_rdata                <= next_rdata;
		end
	end

	// ****************************************
	// Match logic
	// ****************************************
	logic addr_hit;
	logic data_hit;
	logic cp_ok;
	logic id_ok;
	logic rw_ok;
	logic sz_ok;
	logic next_match_b;

	bcb_mask_cmp #(.W(32)) u_addr_cmp (
		.i_value (i_mon_addr),
		.i_ref   (i_break_addr_b),
		.i_mask  ({i_addr_mask_b_high, addr_mask_b_low_bits}),
		.o_hit   (addr_hit)
	);

	bcb_mask_cmp #(.W(32)) u_data_cmp (
		.i_value (i_mon_data),
		.i_ref   ({break_data_b_high_bits, break_data_b_low_bits}),
		.i_mask  ({data_mask_b_high_bits, data_mask_b_low_bits}),
		.o_hit   (data_hit)
	);

	always_comb begin
		cp_ok = i_mon_periph ? cpu_periph_select_b[1] : cpu_periph_select_b[0];
		id_ok = i_mon_fetch ? fetch_data_select_b[0] : fetch_data_select_b[1];
		rw_ok = i_mon_write ? read_write_select_b[1] : read_write_select_b[0];
		sz_ok = (operand_size_select_b == bcb_pkg::BCB_SZ_ANY)
			|| (operand_size_select_b == i_mon_size);
		next_match_b = i_mon_valid & addr_hit & data_hit
			& cp_ok & id_ok & rw_ok & sz_ok;
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_match_b <= 1'b0;
		end else begin
			o_match_b <= next_match_b;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);

	a_addr_mask_low: assert property (
		o_match_b |-> ((($past(i_mon_addr) ^ $past(i_break_addr_b)) & ~{16'hffff,
			$past(addr_mask_b_low_bits)}) & 32'h0000ffff) == 32'h0
	) else $error("Low address compare ignored the mask");

	a_data_high_read: assert property (
		i_rd && i_addr == `BCB_OFS_DATA_HIGH |=> o_rdata == $past(break_data_b_high_bits)
	) else $error("High data register read back wrong");

	a_data_low_wr_rd: assert property (
		i_wr && i_addr == `BCB_OFS_DATA_LOW ##1 i_rd && i_addr == `BCB_OFS_DATA_LOW
		|=> o_rdata == $past(i_wdata, 2)
	) else $error("Low data register lost a write");

	a_data_mask_high: assert property (
		o_match_b |-> ((($past(i_mon_data) ^ {$past(break_data_b_high_bits), 16'h0})
			& ~{$past(data_mask_b_high_bits), 16'hffff})) == 32'h0
	) else $error("High data compare ignored the mask");

	a_data_mask_low: assert property (
		o_match_b |-> ((($past(i_mon_data) ^ {16'h0, $past(break_data_b_low_bits)})
			& ~{16'hffff, $past(data_mask_b_low_bits)})) == 32'h0
	) else $error("Low data compare ignored the mask");

	a_rsvd_reads_zero: assert property (
		i_rd && i_addr == `BCB_OFS_CYCLE_SELECT |=> o_rdata[15:8] == 8'h00
	) else $error("Cycle select upper byte not zero");

	a_cpu_periph_sel: assert property (
		i_mon_valid && cpu_periph_select_b == 2'h1 && i_mon_periph |=> !o_match_b
	) else $error("Peripheral cycle matched with CPU-only select");

	a_fetch_data_sel: assert property (
		i_mon_valid && fetch_data_select_b == 2'h2 && i_mon_fetch |=> !o_match_b
	) else $error("Fetch cycle matched with data-only select");

	a_read_write_sel: assert property (
		i_mon_valid && read_write_select_b == 2'h1 && i_mon_write |=> !o_match_b
	) else $error("Write cycle matched with read-only select");

	a_size_sel: assert property (
		o_match_b |-> $past(operand_size_select_b) == 2'h0
			|| $past(operand_size_select_b) == $past(i_mon_size)
	) else $error("Size mismatch produced a match");

	a_full_match: assert property (
		i_mon_valid && i_mon_addr == i_break_addr_b
		&& i_mon_data == {break_data_b_high_bits, break_data_b_low_bits}
		&& cycle_select == 8'hfc |=> o_match_b
	) else $error("Exact match with all selects open missed");

	a_no_valid_no_match: assert property (
		!i_mon_valid |=> !o_match_b
	) else $error("Match without a monitored cycle");

	c_match_cpu: cover property (i_mon_valid && !i_mon_periph ##1 o_match_b);
	c_match_periph: cover property (i_mon_valid && i_mon_periph ##1 o_match_b);
	c_match_masked: cover property (o_match_b && $past(data_mask_b_low_bits) != 16'h0);
	c_sel_write_rd: cover property (
		i_wr && i_addr == `BCB_OFS_CYCLE_SELECT ##1 i_rd && i_addr == `BCB_OFS_CYCLE_SELECT
	);

endmodule

//--- verif/bcb_mon_model.sv
// Model of the monitored processor and peripheral bus
`timescale 1ns/1ps
module bcb_mon_model (
	// Clock
	input  wire logic        i_clk,
	// Monitored cycle
	output logic             o_valid,
	output logic      [31:0] o_addr,
	output logic      [31:0] o_data,
	output logic             o_periph,
	output logic             o_fetch,
	output logic             o_write,
	output logic      [1:0]  o_size
);
	initial begin
		o_valid = 1'b0;
		o_addr = 32'h0;
		o_data = 32'h0;
		{o_periph, o_fetch, o_write, o_size} = 5'h00;
	end
	// One cycle; released lines show the inverse of the last value
	task automatic cyc(logic [2:0] k, logic [1:0] sz, logic [31:0] a, logic [31:0] d);
		o_valid <= 1'b1;
		o_addr <= a;
		o_data <= d;
		{o_periph, o_fetch, o_write} <= k;
		o_size <= sz;
		@(posedge i_clk);
		o_valid <= 1'b0;
		{o_periph, o_fetch, o_write} <= ~k;
		o_addr <= ~a;
		o_data <= ~d;
		o_size <= ~sz;
	endtask
endmodule

//--- verif/bcb_top_test.sv
// Self-checking bench of the channel B break conditions
`timescale 1ns/1ps
`include "bcb_defs.svh"
module bcb_top_test;
	logic        i_clk;
	logic        i_sys_rst;
	logic [31:0] i_addr;
	logic [15:0] i_wdata;
	logic        i_wr;
	logic        i_rd;
	logic [15:0] o_rdata;
	logic [31:0] i_break_addr_b;
	logic [15:0] i_addr_mask_b_high;
	logic        i_mon_valid, i_mon_periph, i_mon_fetch, i_mon_write, o_match_b;
	logic [31:0] i_mon_addr, i_mon_data;
	logic [1:0]  i_mon_size;
	int          n_errors, checks_done;
	localparam logic [31:0] BA = 32'h0040a5c0;
	localparam logic [31:0] BD = 32'h12345678;
	localparam logic [31:0] RA [6] = '{`BCB_OFS_DATA_HIGH, `BCB_OFS_DATA_LOW,
		`BCB_OFS_DATA_MASK_HIGH, `BCB_OFS_DATA_MASK_LOW, `BCB_OFS_ADDR_MASK_LOW,
		`BCB_OFS_CYCLE_SELECT};
	always #4 i_clk = ~i_clk;
	bcb_top bcb_top_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_break_addr_b(i_break_addr_b), .i_addr_mask_b_high(i_addr_mask_b_high),
		.i_mon_valid(i_mon_valid), .i_mon_addr(i_mon_addr), .i_mon_data(i_mon_data),
		.i_mon_periph(i_mon_periph), .i_mon_fetch(i_mon_fetch),
		.i_mon_write(i_mon_write), .i_mon_size(i_mon_size), .o_match_b(o_match_b));
	bcb_mon_model bcb_mon_model_i (.i_clk(i_clk), .o_valid(i_mon_valid),
		.o_addr(i_mon_addr), .o_data(i_mon_data), .o_periph(i_mon_periph),
		.o_fetch(i_mon_fetch), .o_write(i_mon_write), .o_size(i_mon_size));
	// ****
	// Shared tasks
	// ****
	task automatic test_done();
		$display("checks %0d, errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic cmp16(string nm, logic [15:0] e, logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic cmp1(string nm, logic e, logic g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s exp %b got %b", nm, e, g);
		end
	endtask
	task automatic wr(logic [31:0] a, logic [15:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic wr_rd(logic [31:0] a, logic [15:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		cmp16("rdata after write", d, o_rdata);
		@(posedge i_clk);
	endtask
	task automatic rd(logic [31:0] a, logic [15:0] e);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		cmp16("rdata", e, o_rdata);
		@(posedge i_clk);
	endtask
	task automatic mon(logic [2:0] k, logic [1:0] sz, logic [31:0] a, d, logic e);
		bcb_mon_model_i.cyc(k, sz, a, d);
		@(negedge i_clk);
		cmp1("match", e, o_match_b);
		@(negedge i_clk);
		cmp1("match end", 1'b0, o_match_b);
		@(posedge i_clk);
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_reset();
		for (int i = 0; i < 6; i++) rd(RA[i], 16'h0000);
		rd(32'hffffff6a, 16'h0000);
		$display("reset test done");
	endtask
	task automatic t_regs();
		for (int i = 0; i < 5; i++) wr(RA[i], 16'ha5c3 ^ 16'(i));
		for (int i = 0; i < 5; i++) rd(RA[i], 16'ha5c3 ^ 16'(i));
		wr(`BCB_OFS_CYCLE_SELECT, 16'hffff);
		rd(`BCB_OFS_CYCLE_SELECT, 16'h00ff);
		wr(32'hffffff6a, 16'hffff);
		rd(32'hffffff6a, 16'h0000);
		for (int i = 0; i < 5; i++) wr(RA[i], 16'h0000);
		$display("register test done");
	endtask
	task automatic t_sel();
		logic [7:0] s;
		for (int f = 0; f < 3; f++) begin
			for (int c = 0; c < 4; c++) begin
				s = (8'hfc & ~(8'hc0 >> (2 * f))) | 8'(c << (6 - 2 * f));
				wr(`BCB_OFS_CYCLE_SELECT, {8'h00, s});
				for (int b = 0; b < 2; b++) begin
					mon({f == 0 && b == 1, f == 1 && b == 0, f == 2 && b == 1}, 2'h1,
						BA, 32'h0, 1'(c >> b));
				end
			end
		end
		for (int s2 = 0; s2 < 4; s2++) begin
			wr(`BCB_OFS_CYCLE_SELECT, {8'h00, 6'h3f, 2'(s2)});
			for (int m = 1; m < 4; m++) mon(3'h0, 2'(m), BA, 0, s2 == 0 || s2 == m);
		end
		$display("select test done");
	endtask
	task automatic t_mask();
		wr(`BCB_OFS_CYCLE_SELECT, 16'h00fc);
		wr(`BCB_OFS_DATA_HIGH, BD[31:16]);
		wr_rd(`BCB_OFS_DATA_LOW, BD[15:0]);
		mon(3'h0, 2'h2, BA, BD, 1'b1);
		mon(3'h0, 2'h2, BA, BD ^ 32'h80000000, 1'b0);
		wr(`BCB_OFS_DATA_MASK_HIGH, 16'h8000);
		mon(3'h0, 2'h2, BA, BD ^ 32'h80000000, 1'b1);
		mon(3'h0, 2'h2, BA, BD ^ 32'h00010000, 1'b0);
		mon(3'h0, 2'h2, BA, BD ^ 32'h1, 1'b0);
		wr(`BCB_OFS_DATA_MASK_LOW, 16'h0001);
		mon(3'h0, 2'h2, BA, BD ^ 32'h1, 1'b1);
		mon(3'h0, 2'h2, BA ^ 32'h1, BD, 1'b0);
		wr(`BCB_OFS_ADDR_MASK_LOW, 16'h0001);
		mon(3'h0, 2'h2, BA ^ 32'h1, BD, 1'b1);
		mon(3'h0, 2'h2, BA ^ 32'h2, BD, 1'b0);
		i_addr_mask_b_high <= 16'h0001;
		mon(3'h0, 2'h2, BA ^ 32'h10000, BD, 1'b1);
		$display("mask test done");
	endtask
	initial begin
		i_clk = 1'b0;
		i_sys_rst = 1'b1;
		{i_addr, i_wdata, i_wr, i_rd} = 50'h0;
		i_break_addr_b = BA;
		i_addr_mask_b_high = 16'h0000;
		repeat (8) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		@(posedge i_clk);
		t_reset();
		t_regs();
		t_sel();
		t_mask();
		test_done();
	end
	initial begin
		#100000;
		n_errors++;
		test_done();
	end
endmodule
